// ==== common/standby_consts.svh ====
`ifndef STANDBY_CONSTS_SVH
`define STANDBY_CONSTS_SVH
`define STBY_ADDR_CTRL     4'h0
`define STBY_ADDR_STATUS   4'h1
`define STBY_ADDR_PRIO     4'h2
`define STBY_FLAG_BIT      0
`define STBY_CTRL_UNUSED   7'h00
`define STBY_PRIO_IDLE     3'h7
`define STBY_TB_SEL_RST    2'h0
`define STBY_NMI_RISING    1'b1
`endif

// ==== common/standby_pkg.sv ====
package standby_pkg;
  typedef enum logic [3:0] {
    ST_RUN     = 4'b0001,
    ST_PAUSE   = 4'b0010,
    ST_SERVICE = 4'b0100,
    ST_STOP    = 4'b1000
  } standby_state_t;

  typedef struct packed {
    logic       nmi;
    logic       irq;
    logic [2:0] irq_prio;
    logic       xfer_req;
    logic       xfer_done;
    logic       xfer_release;
  } wake_req_t;

  typedef struct packed {
    logic       halt_instr;
    logic       stop_instr;
    logic       in_isr;
    logic [2:0] isr_prio;
    logic       int_enabled;
  } cpu_status_t;
endpackage : standby_pkg

// ==== design/stabilize_timer.sv ====
`timescale 1ns/1ps
`include "standby_consts.svh"
module stabilize_timer
  import standby_pkg::*;
#(
  parameter int BASE_W = 16
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Control
  input  wire logic       start,
  input  wire logic [1:0] interval_sel,
  // Result
  output logic            done
);
  logic [BASE_W+2:0] cnt_ff;
  logic [BASE_W+2:0] nxt_cnt;
  logic              run_ff;
  logic              nxt_run;
  logic              done_ff;
  logic              nxt_done;
  logic [BASE_W+2:0] half_limit;

  // Half of the selected interval; each step doubles the period
  always_comb begin
    half_limit = '0;
    half_limit[BASE_W - 1 + 32'(interval_sel)] = 1'b1;
  end

  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_run  = run_ff;
    nxt_done = 1'b0;
    if (start) begin
      nxt_cnt = '0;
      nxt_run = 1'b1;
    end else if (run_ff) begin
      if (cnt_ff == half_limit - 1'b1) begin
        nxt_run  = 1'b0;
        nxt_done = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_ff  <= '0;
      run_ff  <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      run_ff  <= nxt_run;
      done_ff <= nxt_done;
    end
  end

  assign done = done_ff;
endmodule : stabilize_timer

// ==== design/standby_control.sv ====
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "standby_consts.svh"
module standby_control
  import standby_pkg::*;
#(
  parameter int TB_BASE_W = 16
) (
  // Clock and resets
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        por,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Processor and interrupt controller
  input  wire cpu_status_t cpu_stat,
  input  wire wake_req_t   wake,
  input  wire logic        nmi_pin,
  // Clock gating and wake answers
  output logic             cpu_clk_en,
  output logic             periph_clk_en,
  output logic             osc_en,
  output logic             take_vector,
  output logic             tb_irq_block
);
  //////////////////////////////////////////////////////////////////////////
  standby_state_t state_ff;
  standby_state_t nxt_state;
  logic           flag_ff;
  logic           nxt_flag;
  logic [1:0]     tb_sel_ff;
  logic [1:0]     nxt_tb_sel;
  logic [7:0]     rdata_ff;
  logic [7:0]     nxt_rdata;
  logic           vec_ff;
  logic           nxt_vec;
  logic           hold_ff;
  logic           nxt_hold;
  logic           pause_isr_ff;
  logic           nxt_pause_isr;
  logic [2:0]     pause_prio_ff;
  logic [2:0]     nxt_pause_prio;
  logic           nmi_s1_ff;
  logic           nmi_s2_ff;
  logic           nmi_s3_ff;
  logic           nmi_edge;
  logic           stab_start;
  logic           stab_done;
  logic           wake_hit;

  // Lower number means higher priority
  function automatic logic irq_wakes(input logic isr, input logic [2:0] cur,
                                     input logic [2:0] req);
    irq_wakes = !isr || (req < cur);
  endfunction : irq_wakes

  //////////////////////////////////////////////////////////////////////////
  // Pin synchroniser; edge seen only past the second stage
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      nmi_s1_ff <= 1'b0;
      nmi_s2_ff <= 1'b0;
      nmi_s3_ff <= 1'b0;
    end else begin
      nmi_s1_ff <= nmi_pin;
      nmi_s2_ff <= nmi_s1_ff;
      nmi_s3_ff <= nmi_s2_ff;
    end
  end

  assign nmi_edge = `STBY_NMI_RISING ? (nmi_s2_ff && !nmi_s3_ff)
                                     : (!nmi_s2_ff && nmi_s3_ff);

  //////////////////////////////////////////////////////////////////////////
  // Standby flag lives on power-on reset only
  always_comb begin
    nxt_flag = flag_ff;
    if (reg_wr && reg_addr == `STBY_ADDR_CTRL &&
        reg_wdata[`STBY_FLAG_BIT])
      nxt_flag = 1'b1;
  end

  // Not on rst, so a stop return can be told from power-up
  always_ff @(posedge core_clk or posedge por) begin
    if (por) flag_ff <= 1'b0;
    else     flag_ff <= nxt_flag;
  end

  //////////////////////////////////////////////////////////////////////////
  // Register file
  always_comb begin
    nxt_tb_sel = tb_sel_ff;
    if (reg_wr && reg_addr == `STBY_ADDR_STATUS)
      nxt_tb_sel = reg_wdata[1:0];
    nxt_rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `STBY_ADDR_CTRL:   nxt_rdata = {`STBY_CTRL_UNUSED, flag_ff};
        `STBY_ADDR_STATUS: nxt_rdata = {2'h0, state_ff, tb_sel_ff};
        `STBY_ADDR_PRIO:   nxt_rdata = {4'h0, pause_isr_ff, pause_prio_ff};
        default:           nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tb_sel_ff <= `STBY_TB_SEL_RST;
      rdata_ff  <= 8'h00;
    end else begin
      tb_sel_ff <= nxt_tb_sel;
      rdata_ff  <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  //////////////////////////////////////////////////////////////////////////
  // Standby state machine
  assign wake_hit = wake.nmi ||
    (wake.irq && irq_wakes(pause_isr_ff, pause_prio_ff, wake.irq_prio));

  always_comb begin
    nxt_state      = state_ff;
    nxt_vec        = 1'b0;
    nxt_hold       = hold_ff;
    nxt_pause_isr  = pause_isr_ff;
    nxt_pause_prio = pause_prio_ff;
    stab_start     = 1'b0;
    unique case (state_ff)
      ST_RUN: begin
        if (cpu_stat.halt_instr) begin
          nxt_pause_isr  = cpu_stat.in_isr;
          nxt_pause_prio = cpu_stat.in_isr ? cpu_stat.isr_prio
                                           : `STBY_PRIO_IDLE;
          // Early request skips the pause entirely
          if (wake.nmi || wake.irq || wake.xfer_req)
            nxt_state = ST_RUN;
          else
            nxt_state = ST_PAUSE;
        end else if (cpu_stat.stop_instr) begin
          nxt_state = ST_STOP;
        end
      end
      ST_PAUSE: begin
        if (wake_hit) begin
          nxt_state = ST_RUN;
          nxt_vec   = wake.nmi || cpu_stat.int_enabled;
        end else if (wake.xfer_req) begin
          nxt_state = ST_SERVICE;
        end
      end
      ST_SERVICE: begin
        if (wake.xfer_done) begin
          if (wake.xfer_release) begin
            nxt_state = ST_RUN;
            nxt_vec   = cpu_stat.int_enabled;
          end else begin
            nxt_state = ST_PAUSE;
          end
        end
      end
      ST_STOP: begin
        if (!hold_ff && nmi_edge) begin
          nxt_hold   = 1'b1;
          stab_start = 1'b1;
        end else if (hold_ff && stab_done) begin
          nxt_hold  = 1'b0;
          nxt_state = ST_RUN;
          nxt_vec   = 1'b1;
        end
      end
    endcase
  end

  // Reset exits any state to run as a cold start would, but keeps the standby flag
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_ff      <= ST_RUN;
      vec_ff        <= 1'b0;
      hold_ff       <= 1'b0;
      pause_isr_ff  <= 1'b0;
      pause_prio_ff <= `STBY_PRIO_IDLE;
    end else begin
      state_ff      <= nxt_state;
      vec_ff        <= nxt_vec;
      hold_ff       <= nxt_hold;
      pause_isr_ff  <= nxt_pause_isr;
      pause_prio_ff <= nxt_pause_prio;
    end
  end

  stabilize_timer #(
    .BASE_W       (TB_BASE_W)
  ) stabilize_timer_inst (
    .core_clk     (core_clk),
    .rst          (rst),
    .start        (stab_start),
    .interval_sel (tb_sel_ff),
    .done         (stab_done)
  );

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  assign cpu_clk_en    = (state_ff == ST_RUN) || (state_ff == ST_SERVICE);
  assign periph_clk_en = (state_ff != ST_STOP);
  assign osc_en        = (state_ff != ST_STOP) || hold_ff;
  assign take_vector   = vec_ff;
  assign tb_irq_block  = hold_ff;

  //////////////////////////////////////////////////////////////////////////
  // Checks
  pause_gate_a: assert property (@(posedge core_clk) disable iff (rst)
    state_ff == ST_PAUSE |-> !cpu_clk_en && periph_clk_en)
    else $error("pause state does not gate only cpu clock");
  stop_gate_a: assert property (@(posedge core_clk) disable iff (rst)
    state_ff == ST_STOP && !hold_ff |-> !osc_en && !periph_clk_en)
    else $error("stop state leaves clocks running");
  entry_instr_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(state_ff == ST_STOP) |-> $past(cpu_stat.stop_instr))
    else $error("stop entered without instruction");
  ctrl_upper_a: assert property (@(posedge core_clk) disable iff (rst)
    $past(reg_rd) && $past(reg_addr) == `STBY_ADDR_CTRL
      |-> reg_rdata[7:1] == 7'h00 && reg_rdata[0] == $past(flag_ff))
    else $error("control register read wrong");
  flag_sticky_a: assert property (@(posedge core_clk) disable iff (por)
    flag_ff |=> flag_ff)
    else $error("flag cleared without power-on");
  flag_set_a: assert property (@(posedge core_clk) disable iff (por)
    reg_wr && reg_addr == `STBY_ADDR_CTRL && reg_wdata[0] |=> flag_ff)
    else $error("flag write did not set");
  pause_wake_a: assert property (@(posedge core_clk) disable iff (rst)
    state_ff == ST_PAUSE && wake.nmi |=> state_ff == ST_RUN && vec_ff)
    else $error("nmi did not release pause");
  prio_block_a: assert property (@(posedge core_clk) disable iff (rst)
    state_ff == ST_PAUSE && pause_isr_ff && !wake.nmi && !wake.xfer_req &&
    wake.irq && wake.irq_prio >= pause_prio_ff |=> state_ff == ST_PAUSE)
    else $error("lower priority request released pause");
  early_wake_a: assert property (@(posedge core_clk) disable iff (rst)
    state_ff == ST_RUN && cpu_stat.halt_instr && wake.irq
      |=> state_ff == ST_RUN)
    else $error("early request still paused");
  stop_hold_a: assert property (@(posedge core_clk) disable iff (rst)
    state_ff == ST_STOP && hold_ff |-> !cpu_clk_en && tb_irq_block)
    else $error("clock released during stabilisation");
  // Wake and exit paths; a transfer return is not an entry by instruction
  pause_entry_a: assert property (@(posedge core_clk) disable iff (rst)
    $rose(state_ff == ST_PAUSE)
      |-> $past(cpu_stat.halt_instr) || $past(state_ff) == ST_SERVICE)
    else $error("pause entered without instruction");
  rst_flag_a: assert property (@(posedge core_clk) disable iff (por)
    rst && !reg_wr |=> flag_ff == $past(flag_ff))
    else $error("external reset changed flag");
  early_xfer_a: assert property (@(posedge core_clk) disable iff (rst)
    state_ff == ST_RUN && cpu_stat.halt_instr &&
    (wake.nmi || wake.xfer_req) |=> state_ff == ST_RUN)
    else $error("early nmi or transfer still paused");
  service_clk_a: assert property (@(posedge core_clk) disable iff (rst)
    state_ff == ST_SERVICE |-> cpu_clk_en && periph_clk_en)
    else $error("transfer service without clock");
  xfer_back_a: assert property (@(posedge core_clk) disable iff (rst)
    state_ff == ST_SERVICE && wake.xfer_done && !wake.xfer_release
      |=> state_ff == ST_PAUSE)
    else $error("transfer did not return to pause");
  prio_wake_a: assert property (@(posedge core_clk) disable iff (rst)
    state_ff == ST_PAUSE && wake.irq && wake.irq_prio < pause_prio_ff
      |=> state_ff == ST_RUN)
    else $error("higher priority request did not release pause");
  free_wake_a: assert property (@(posedge core_clk) disable iff (rst)
    state_ff == ST_PAUSE && !pause_isr_ff && wake.irq |=> state_ff == ST_RUN)
    else $error("request outside service did not release pause");
  vector_pick_a: assert property (@(posedge core_clk) disable iff (rst)
    state_ff == ST_PAUSE && !pause_isr_ff && wake.irq && !wake.nmi
      |=> take_vector == $past(cpu_stat.int_enabled))
    else $error("vector choice does not follow enable");
  stop_exit_a: assert property (@(posedge core_clk) disable iff (rst)
    state_ff == ST_STOP && !hold_ff && !nmi_edge
      |=> state_ff == ST_STOP && !hold_ff)
    else $error("stop left without nmi edge");
  stab_osc_a: assert property (@(posedge core_clk) disable iff (rst)
    state_ff == ST_STOP && hold_ff |-> osc_en && !periph_clk_en)
    else $error("oscillator off during stabilisation");
  reset_exit_a: assert property (@(posedge core_clk) disable iff (rst)
    $fell(rst)
      |-> state_ff == ST_RUN && !take_vector && !tb_irq_block)
    else $error("reset did not return to run");
endmodule : standby_control

// ==== tb/wake_source_model.sv ====
`timescale 1ns/1ps
module wake_source_model
  import standby_pkg::*;
(
  // Clock
  input  wire logic core_clk,
  // Toward the block
  output cpu_status_t cpu_stat,
  output wake_req_t   wake
);
  initial begin
    cpu_stat = '0;
    wake     = '0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Context levels only move between instructions
  task automatic set_ctx(input logic isr, input logic [2:0] pr,
                         input logic en);
    @(posedge core_clk);
    cpu_stat.in_isr      <= isr;
    cpu_stat.isr_prio    <= pr;
    cpu_stat.int_enabled <= en;
  endtask : set_ctx
  // One-cycle pulses; the idle slot after acts as the nop
  task automatic pulse(input logic h, input logic s, input wake_req_t w);
    @(posedge core_clk);
    cpu_stat.halt_instr <= h;
    cpu_stat.stop_instr <= s;
    wake                <= w;
    @(posedge core_clk);
    cpu_stat.halt_instr <= 1'b0;
    cpu_stat.stop_instr <= 1'b0;
    wake                <= '0;
  endtask : pulse
endmodule : wake_source_model

// ==== tb/standby_control_test.sv ====
`timescale 1ns/1ps
module standby_control_test
  import standby_pkg::*;
  ;
  logic        core_clk;
  logic        rst;
  logic        por;
  logic [3:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        nmi_pin;
  logic        cpu_clk_en;
  logic        periph_clk_en;
  logic        osc_en;
  logic        take_vector;
  logic        tb_irq_block;
  cpu_status_t cpu_stat;
  wake_req_t   wake;
  int          fails;
  int          checked;
  int          blk;
  // Short timebase keeps the stop wake to a few cycles
  standby_control #(.TB_BASE_W(4)) standby_control_inst (
    .core_clk(core_clk), .rst(rst), .por(por), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .cpu_stat(cpu_stat), .wake(wake),
    .nmi_pin(nmi_pin), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .osc_en(osc_en),
    .take_vector(take_vector), .tb_irq_block(tb_irq_block));
  wake_source_model wake_source_model_inst (
    .core_clk(core_clk), .cpu_stat(cpu_stat), .wake(wake));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask : rd
  // Wake bits: nmi, irq, prio[2:0], xfer req, done, release
  task automatic pl(input logic h, input logic s, input logic [7:0] w);
    wake_source_model_inst.pulse(h, s, wake_req_t'(w));
    #1;
  endtask : pl
  task automatic hw_reset();
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
  endtask : hw_reset
  // Waits for the clock to return and counts blocked cycles
  task automatic wait_wake();
    blk = 0;
    for (int i = 0; i < 100 && cpu_clk_en !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
      if (tb_irq_block === 1'b1) blk++;
    end
    if (cpu_clk_en !== 1'b1) begin
      fails++;
      $display("CHECK FAILED at %0t: clock never returned", $time);
      close_out();
    end
  endtask : wait_wake
  //////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(4'h0, 8'h00);
    wr(4'h0, 8'hFE);
    rd(4'h0, 8'h00);
    wr(4'h0, 8'hFF);
    rd(4'h0, 8'h01);
    wr(4'h0, 8'h00);
    rd(4'h0, 8'h01);
    rd(4'hF, 8'h00);
    hw_reset();
    rd(4'h0, 8'h01);
  endtask : t_regs
  task automatic t_pause();
    wake_source_model_inst.set_ctx(1'b0, 3'h7, 1'b1);
    pl(1'b1, 1'b0, 8'h00);
    chk({cpu_clk_en, periph_clk_en, osc_en}, 8'h03);
    pl(1'b0, 1'b0, 8'h78);
    chk({cpu_clk_en, take_vector}, 8'h03);
  endtask : t_pause
  task automatic t_isr();
    wake_source_model_inst.set_ctx(1'b1, 3'h3, 1'b0);
    pl(1'b1, 1'b0, 8'h00);
    pl(1'b0, 1'b0, 8'h58);
    chk(cpu_clk_en, 8'h00);
    rd(4'h2, 8'h0B);
    rd(4'h1, 8'h08);
    pl(1'b0, 1'b0, 8'h50);
    chk({cpu_clk_en, take_vector}, 8'h02);
    pl(1'b1, 1'b0, 8'h00);
    pl(1'b0, 1'b0, 8'h80);
    chk(cpu_clk_en, 8'h01);
    wake_source_model_inst.set_ctx(1'b0, 3'h7, 1'b1);
  endtask : t_isr
  task automatic t_early();
    logic [7:0] w [3] = '{8'h78, 8'h80, 8'h04};
    foreach (w[i]) begin
      pl(1'b1, 1'b0, w[i]);
      repeat (3) @(posedge core_clk);
      #1 chk(cpu_clk_en, 8'h01);
    end
  endtask : t_early
  task automatic t_xfer();
    pl(1'b1, 1'b0, 8'h00);
    pl(1'b0, 1'b0, 8'h04);
    chk(cpu_clk_en, 8'h01);
    pl(1'b0, 1'b0, 8'h02);
    chk(cpu_clk_en, 8'h00);
    pl(1'b0, 1'b0, 8'h04);
    pl(1'b0, 1'b0, 8'h03);
    chk({cpu_clk_en, take_vector}, 8'h03);
  endtask : t_xfer
  // Stabilisation is 2**(4-1) cycles with select 0
  task automatic t_stop();
    wr(4'h0, 8'h01);
    pl(1'b0, 1'b1, 8'h00);
    chk({cpu_clk_en, periph_clk_en, osc_en}, 8'h00);
    pl(1'b0, 1'b0, 8'h78);
    pl(1'b0, 1'b0, 8'h04);
    chk(osc_en, 8'h00);
    @(posedge core_clk);
    nmi_pin <= 1'b1;
    wait_wake();
    chk({take_vector, tb_irq_block}, 8'h02);
    chk(8'(blk >= 8 && blk <= 12), 8'h01);
    @(posedge core_clk);
    nmi_pin <= 1'b0;
    rd(4'h0, 8'h01);
    // Select 1 doubles the wait to 2**4 cycles
    wr(4'h1, 8'h01);
    rd(4'h1, 8'h05);
    pl(1'b0, 1'b1, 8'h00);
    @(posedge core_clk);
    nmi_pin <= 1'b1;
    wait_wake();
    chk(8'(blk >= 16 && blk <= 20), 8'h01);
    @(posedge core_clk);
    nmi_pin <= 1'b0;
  endtask : t_stop
  task automatic t_rst();
    pl(1'b1, 1'b0, 8'h00);
    hw_reset();
    #1 chk({cpu_clk_en, periph_clk_en, osc_en, take_vector, tb_irq_block},
           8'h1C);
    pl(1'b0, 1'b1, 8'h00);
    hw_reset();
    #1 chk({cpu_clk_en, periph_clk_en, osc_en, take_vector, tb_irq_block},
           8'h1C);
    rd(4'h0, 8'h01);
  endtask : t_rst
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    rst       = 1'b1;
    por       = 1'b1;
    reg_addr  = 4'h0;
    reg_wdata = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    nmi_pin   = 1'b0;
    fails     = 0;
    checked   = 0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    por <= 1'b0;
    t_regs();
    t_pause();
    t_isr();
    t_early();
    t_xfer();
    t_stop();
    t_rst();
    close_out();
  end
endmodule : standby_control_test
